// File: hdl/acr_pkg.sv
`default_nettype none

package acr_pkg;

  // ==========================================================================
  // clock and result width
  // ==========================================================================
  localparam int CLK_NS      = 8;
  localparam int CLK_PS      = 8000;
  localparam int RESULT_BITS = 18;
  localparam int TIMER_BITS  = 8;

  // minimum figures round up, maximum figures round down, never below one
  function automatic int cyc_min(input int ns); // (R19)
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int cyc_max(input int ns); // (R19)
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_max

  // ==========================================================================
  // conversion timing
  // ==========================================================================
  localparam int T_CONV_FAST_MAX_NS   = 385;
  localparam int T_CONV_NORMAL_MAX_NS = 520;
  // conversion runs shorter than its limit so that master read after
  // convert still meets the busy ceiling at the fastest divider
  localparam int T_CONV_FAST_NS       = 290;
  localparam int T_CONV_NORMAL_NS     = 480;
  localparam int CONV_FAST_CYC        = cyc_max(T_CONV_FAST_NS);
  localparam int CONV_NORMAL_CYC      = cyc_max(T_CONV_NORMAL_NS);
  localparam int T_EOC_BUSY_NS        = 10;
  localparam int EOC_BUSY_CYC         = cyc_min(T_EOC_BUSY_NS);
  localparam int T_RST_BUSY_NS        = 10;
  localparam int RST_BUSY_CYC         = cyc_min(T_RST_BUSY_NS);
  localparam int T_RST_HOLD_NS        = 600;
  localparam int RST_HOLD_CYC         = cyc_min(T_RST_HOLD_NS);

  // ==========================================================================
  // master serial timing
  // ==========================================================================
  localparam int T_SYNC_FAST_NS   = 14;
  localparam int T_SYNC_NORMAL_NS = 137;
  localparam int SYNC_FAST_CYC    = cyc_min(T_SYNC_FAST_NS);
  localparam int SYNC_NORMAL_CYC  = cyc_min(T_SYNC_NORMAL_NS);
  localparam int T_LEAD_PS        = 500;
  localparam int LEAD_CYC         = (T_LEAD_PS + CLK_PS - 1) / CLK_PS;
  localparam int T_SYNC_BUSY_NS   = 13;
  localparam int SYNC_BUSY_CYC    = cyc_min(T_SYNC_BUSY_NS);
  localparam int T_SCLK0_NS       = 8;
  localparam int T_SCLK1_NS       = 16;
  localparam int T_SCLK2_NS       = 32;
  localparam int T_SCLK3_NS       = 64;
  // a full serial clock period takes at least two reference cycles
  localparam int HALF0_CYC        = cyc_min(T_SCLK0_NS / 2);
  localparam int HALF1_CYC        = cyc_min(T_SCLK1_NS / 2);
  localparam int HALF2_CYC        = cyc_min(T_SCLK2_NS / 2);
  localparam int HALF3_CYC        = cyc_min(T_SCLK3_NS / 2);

  // ==========================================================================
  // modes and carriers
  // ==========================================================================
  typedef enum logic [1:0] {
    SPD_NORMAL,
    SPD_FAST,
    SPD_WIDE_FAST
  } acr_speed_t;

  typedef enum logic [1:0] {
    RD_PARALLEL,
    RD_MASTER_DURING,
    RD_MASTER_AFTER,
    RD_SLAVE
  } acr_read_t;

  typedef struct packed {
    logic value;
    logic oe;
  } acr_pin_t;

endpackage : acr_pkg

`default_nettype wire

// File: hdl/acr_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module acr_sync3 #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // pins and filtered levels
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
    end
    else
    begin
      s1 <= async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit changes only once the second and third stage agree
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      level <= RESET_VAL;
    else
      level <= (s2 & ~(s2 ^ s3)) | (level & (s2 ^ s3));
  end

endmodule : acr_sync3

`default_nettype wire

// File: hdl/acr_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) host spaces convert pulses 500/667 ns
// (R2) fast mode: next conversion within 1 ms
// (R3) wide-band fast timing equals fast timing
// (R4) busy rises promptly after convert falls
// (R5) conversion ends within 385/520 ns
// (R6) busy falls at least 10 ns after end
// (R7) host allows 115 ns acquisition time
// (R8) after reset: busy delayed, held 600 ns
// (R9) parallel data valid within conversion time
// (R10) parallel data valid before busy falls
// (R11) chip select low enables serial outputs
// (R12) chip select high floats serial outputs
// (R13) frame marker 14/137 ns after convert
// (R14) marker leads first edge, trails last
// (R15) busy falls 13 ns after marker drops
// (R16) divider sets minimum serial clock period
// (R17) read-after-convert busy stays under ceiling
// (R18) slave data updates after host clock edge
// (R19) ns limits become rounded clock counts
module acr_conv_ctrl (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  // host pins
  input  wire logic                            convert_start_n,
  input  wire logic                            adcReset,
  input  wire logic                            chipSelect_n,
  input  wire logic                            slaveSerialClock,
  input  wire logic                            serial_data_chain_in,
  // configuration
  input  wire acr_pkg::acr_speed_t             speedMode,
  input  wire acr_pkg::acr_read_t              readMode,
  input  wire logic [1:0]                      serial_clock_divider,
  // converter core
  input  wire logic [acr_pkg::RESULT_BITS-1:0] coreResult,
  output logic                                 sampleHold,
  // results and status
  output logic                                 busy,
  output logic [acr_pkg::RESULT_BITS-1:0]      parallelData,
  output acr_pkg::acr_pin_t                    frameMarker,
  output acr_pkg::acr_pin_t                    serialClock,
  output acr_pkg::acr_pin_t                    serial_data_out
);

  // ==========================================================================
  // reset release and pin synchronisers
  // ==========================================================================
  logic rstMeta;
  logic rstN;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  logic [4:0] pinLevel;

  acr_sync3 #(
    .W         (5),
    .RESET_VAL (5'h05)
  ) u_sync (
    .clk   (ref_clk),
    .rstN  (rstN),
    .async ({serial_data_chain_in, slaveSerialClock, chipSelect_n,
             adcReset, convert_start_n}),
    .level (pinLevel)
  );

  logic cnvLvl;
  logic rstLvl;
  logic csLvl;
  logic sckLvl;
  logic chainLvl;
  logic cnvPrev;
  logic rstPrev;
  logic sckPrev;

  assign cnvLvl   = pinLevel[0];
  assign rstLvl   = pinLevel[1];
  assign csLvl    = pinLevel[2];
  assign sckLvl   = pinLevel[3];
  assign chainLvl = pinLevel[4];

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cnvPrev <= 1'b1;
      rstPrev <= 1'b0;
      sckPrev <= 1'b0;
    end
    else
    begin
      cnvPrev <= cnvLvl;
      rstPrev <= rstLvl;
      sckPrev <= sckLvl;
    end
  end

  logic cnvFall;
  logic rstFall;
  logic sckRise;
  logic fastMode;
  logic masterMode;

  assign cnvFall    = cnvPrev & ~cnvLvl;
  assign rstFall    = rstPrev & ~rstLvl;
  assign sckRise    = ~sckPrev & sckLvl;
  assign fastMode   = (speedMode != acr_pkg::SPD_NORMAL); // (R3)
  assign masterMode = (readMode == acr_pkg::RD_MASTER_DURING) ||
                      (readMode == acr_pkg::RD_MASTER_AFTER);

  // ==========================================================================
  // conversion sequencer
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESET,
    ST_RST_DLY,
    ST_RST_HOLD,
    ST_CONV,
    ST_EOC
  } acr_state_t;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_LEAD,
    SER_SHIFT,
    SER_TAIL
  } acr_ser_t;

  acr_state_t                     state;
  acr_ser_t                       serState;
  logic [acr_pkg::TIMER_BITS-1:0] timer;
  logic [acr_pkg::TIMER_BITS-1:0] convLast;
  logic [acr_pkg::TIMER_BITS-1:0] syncLast;
  logic [acr_pkg::TIMER_BITS-1:0] gapCnt;
  logic                           startFrame;
  logic                           frameQuiet;

  assign convLast = fastMode ?
    acr_pkg::TIMER_BITS'(acr_pkg::CONV_FAST_CYC - 1) :
    acr_pkg::TIMER_BITS'(acr_pkg::CONV_NORMAL_CYC - 1); // (R5) (R19)
  assign syncLast = fastMode ?
    acr_pkg::TIMER_BITS'(acr_pkg::SYNC_FAST_CYC - 1) :
    acr_pkg::TIMER_BITS'(acr_pkg::SYNC_NORMAL_CYC - 1);
  // in master modes busy waits for the frame to close and settle
  assign frameQuiet = !masterMode || ((serState == SER_IDLE) &&
    gapCnt >= acr_pkg::TIMER_BITS'(acr_pkg::SYNC_BUSY_CYC)); // (R15)

  assign startFrame =
    ((state == ST_CONV) && (timer == syncLast) &&
     (readMode == acr_pkg::RD_MASTER_DURING)) || // (R13)
    ((state == ST_CONV) && (timer == convLast) &&
     (readMode == acr_pkg::RD_MASTER_AFTER)); // (R17)

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state <= ST_IDLE;
      timer <= '0;
    end
    else if (rstLvl)
    begin
      state <= ST_RESET;
      timer <= '0;
    end
    else
    begin
      timer <= timer + 1'b1;
      case (state)
        ST_RESET:
        begin
          timer <= '0;
          if (rstFall)
            state <= ST_RST_DLY;
        end
        ST_RST_DLY:
          if (timer == acr_pkg::TIMER_BITS'(acr_pkg::RST_BUSY_CYC - 1))
          begin
            state <= ST_RST_HOLD; // (R8)
            timer <= '0;
          end
        ST_RST_HOLD:
          if (timer == acr_pkg::TIMER_BITS'(acr_pkg::RST_HOLD_CYC - 1))
            state <= ST_IDLE; // (R8)
        ST_IDLE:
        begin
          timer <= '0;
          if (cnvFall)
            state <= ST_CONV;
        end
        ST_CONV:
          if (timer == convLast)
          begin
            state <= ST_EOC;
            timer <= '0;
          end
        ST_EOC:
        begin
          if (timer == acr_pkg::TIMER_BITS'(acr_pkg::EOC_BUSY_CYC))
            timer <= timer;
          if ((timer >= acr_pkg::TIMER_BITS'(acr_pkg::EOC_BUSY_CYC - 1)) &&
              frameQuiet)
            state <= ST_IDLE; // (R6)
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // busy from a register; rises the cycle after the synced convert edge
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      busy <= 1'b0;
    else if (rstLvl)
      busy <= 1'b0;
    else
      case (state)
        ST_IDLE:     busy <= cnvFall; // (R4)
        ST_RST_DLY:  busy <= (timer ==
          acr_pkg::TIMER_BITS'(acr_pkg::RST_BUSY_CYC - 1)); // (R8)
        ST_RST_HOLD: busy <= 1'b1;
        ST_CONV:     busy <= 1'b1;
        ST_EOC:      busy <= !((timer >=
          acr_pkg::TIMER_BITS'(acr_pkg::EOC_BUSY_CYC - 1)) && frameQuiet);
        default:     busy <= 1'b0;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      sampleHold <= 1'b0;
    else
      sampleHold <= (state == ST_IDLE) && cnvFall && !rstLvl;
  end

  // result stands from end of conversion, at least two cycles before busy falls
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      parallelData <= '0;
    else if ((state == ST_CONV) && (timer == convLast))
      parallelData <= coreResult; // (R9) (R10)
  end

  // ==========================================================================
  // serial engine
  // ==========================================================================
  logic [acr_pkg::RESULT_BITS-1:0] shiftReg;
  logic [acr_pkg::TIMER_BITS-1:0]  halfLast;
  logic [acr_pkg::TIMER_BITS-1:0]  halfCnt;
  logic [4:0]                      bitCnt;
  logic                            sclk;
  logic                            frame;
  logic                            halfDone;

  always_comb
  begin
    case (serial_clock_divider) // (R16)
      2'h0:    halfLast = acr_pkg::TIMER_BITS'(acr_pkg::HALF0_CYC - 1);
      2'h1:    halfLast = acr_pkg::TIMER_BITS'(acr_pkg::HALF1_CYC - 1);
      2'h2:    halfLast = acr_pkg::TIMER_BITS'(acr_pkg::HALF2_CYC - 1);
      default: halfLast = acr_pkg::TIMER_BITS'(acr_pkg::HALF3_CYC - 1);
    endcase
  end

  assign halfDone = (halfCnt == halfLast);

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      serState <= SER_IDLE;
      halfCnt  <= '0;
      bitCnt   <= '0;
      sclk     <= 1'b0;
      frame    <= 1'b0;
    end
    else
      case (serState)
        SER_IDLE:
          if (startFrame)
          begin
            serState <= SER_LEAD;
            frame    <= 1'b1; // (R14)
            halfCnt  <= '0;
            bitCnt   <= '0;
          end
        SER_LEAD:
        begin
          halfCnt <= halfCnt + 1'b1;
          if (halfCnt == acr_pkg::TIMER_BITS'(acr_pkg::LEAD_CYC - 1))
          begin
            serState <= SER_SHIFT;
            halfCnt  <= '0;
          end
        end
        SER_SHIFT:
        begin
          halfCnt <= halfDone ? '0 : halfCnt + 1'b1;
          if (halfDone)
          begin
            sclk <= ~sclk;
            if (sclk)
            begin
              bitCnt <= bitCnt + 1'b1;
              if (bitCnt == 5'(acr_pkg::RESULT_BITS - 1))
                serState <= SER_TAIL;
            end
          end
        end
        SER_TAIL:
        begin
          frame    <= 1'b0; // (R14)
          serState <= SER_IDLE;
        end
        default:
          serState <= SER_IDLE;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      gapCnt <= '0;
    else if (serState != SER_IDLE)
      gapCnt <= '0;
    else if (gapCnt != acr_pkg::TIMER_BITS'(acr_pkg::SYNC_BUSY_CYC))
      gapCnt <= gapCnt + 1'b1; // (R15)
  end

  // during-convert mode ships the previous result; others the fresh one
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      shiftReg <= '0;
    else if ((state == ST_IDLE) && cnvFall &&
             (readMode == acr_pkg::RD_MASTER_DURING))
      shiftReg <= parallelData;
    else if ((state == ST_CONV) && (timer == convLast) &&
             (readMode != acr_pkg::RD_MASTER_DURING))
      shiftReg <= coreResult;
    else if ((serState == SER_SHIFT) && halfDone && sclk)
      shiftReg <= {shiftReg[acr_pkg::RESULT_BITS-2:0], 1'b0};
    else if ((readMode == acr_pkg::RD_SLAVE) && !csLvl && sckRise)
      shiftReg <= {shiftReg[acr_pkg::RESULT_BITS-2:0], chainLvl}; // (R18)
  end

  // ==========================================================================
  // serial pins
  // ==========================================================================
  logic serialEnable;

  assign serialEnable = !csLvl && (masterMode ||
                        (readMode == acr_pkg::RD_SLAVE));

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      frameMarker     <= '0;
      serialClock     <= '0;
      serial_data_out <= '0;
    end
    else
    begin
      frameMarker.value     <= frame;
      frameMarker.oe        <= masterMode && !csLvl; // (R11) (R12)
      serialClock.value     <= sclk;
      serialClock.oe        <= masterMode && !csLvl; // (R11) (R12)
      serial_data_out.value <= shiftReg[acr_pkg::RESULT_BITS-1];
      serial_data_out.oe    <= serialEnable; // (R11) (R12)
    end
  end

endmodule : acr_conv_ctrl

`default_nettype wire

// File: verif/acr_conv_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module acr_conv_ctrl_checker (
  // clock and reset
  input wire logic                            ref_clk,
  input wire logic                            reset_n,
  // host pins and configuration
  input wire logic                            convert_start_n,
  input wire logic                            adcReset,
  input wire logic                            chipSelect_n,
  input wire acr_pkg::acr_speed_t             speedMode,
  input wire acr_pkg::acr_read_t              readMode,
  input wire logic [1:0]                      serial_clock_divider,
  // device outputs
  input wire logic                            sampleHold,
  input wire logic                            busy,
  input wire logic [acr_pkg::RESULT_BITS-1:0] parallelData,
  input wire acr_pkg::acr_pin_t               frameMarker,
  input wire acr_pkg::acr_pin_t               serialClock,
  input wire acr_pkg::acr_pin_t               serial_data_out
);
  // ====================
  // busy width bookkeeping
  logic [9:0] busyLen;
  logic       convFlag;
  logic [9:0] limMax;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      busyLen <= 10'h000;
    else
      busyLen <= busy ? busyLen + 10'h001 : 10'h000;
  end

  // tells a conversion busy from a converter-reset busy
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      convFlag <= 1'b0;
    else if (sampleHold)
      convFlag <= 1'b1;
    else if (!busy)
      convFlag <= 1'b0;
  end

  always_comb
  begin
    if (readMode == acr_pkg::RD_MASTER_AFTER)
      case (serial_clock_divider)
        2'b00:   limMax = 10'h04E;
        2'b01:   limMax = 10'h06C;
        2'b10:   limMax = 10'h0A8;
        default: limMax = 10'h11D;
      endcase
    else
      limMax = (speedMode == acr_pkg::SPD_NORMAL) ? 10'h041 : 10'h030;
  end

  // ====================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_busy_prompt: assert property (
    $fell(convert_start_n) && !busy |-> ##[1:6] sampleHold)
    else $error("busy late after convert");
  a_hold_with_busy: assert property (
    sampleHold |-> busy && !$past(busy))
    else $error("sample pulse not at busy rise");
  a_conv_bound: assert property (
    $fell(busy) && convFlag |-> busyLen <= limMax)
    else $error("busy high too long");
  a_reset_hold: assert property (
    $fell(busy) && !convFlag |-> busyLen >= 10'h04B)
    else $error("reset busy too short");
  a_reset_rise: assert property (
    $fell(adcReset) |-> ##[1:10] busy)
    else $error("no busy after converter reset");
  a_data_in_busy: assert property (
    $changed(parallelData) |-> busy)
    else $error("result changed outside busy");
  a_cs_float: assert property (
    chipSelect_n [*6] |-> !frameMarker.oe && !serialClock.oe
      && !serial_data_out.oe)
    else $error("serial pins driven with select high");
  a_cs_drive: assert property (
    (!chipSelect_n && readMode == acr_pkg::RD_MASTER_AFTER) [*8]
      |-> frameMarker.oe && serialClock.oe)
    else $error("serial pins not driven");
  a_sclk_in_frame: assert property (
    $rose(serialClock.value) |-> frameMarker.value
      && $past(frameMarker.value))
    else $error("clock edge without leading marker");
  a_frame_trail: assert property (
    $fell(frameMarker.value) |-> !serialClock.value)
    else $error("marker dropped before last edge");
  a_busy_after_frame: assert property (
    $fell(frameMarker.value) |-> busy ##1 busy)
    else $error("busy fell too soon after marker");
  a_sclk_div3: assert property (
    $changed(serialClock.value) && serial_clock_divider == 2'b11
      |=> $stable(serialClock.value) [*3])
    else $error("serial clock half too short");
  a_sclk_div2: assert property (
    $changed(serialClock.value) && serial_clock_divider == 2'b10
      |=> $stable(serialClock.value))
    else $error("serial clock half too short");
endmodule : acr_conv_ctrl_checker

bind acr_conv_ctrl acr_conv_ctrl_checker chk_u (
  .ref_clk, .reset_n, .convert_start_n, .adcReset, .chipSelect_n,
  .speedMode, .readMode, .serial_clock_divider, .sampleHold, .busy,
  .parallelData, .frameMarker, .serialClock, .serial_data_out
);

`default_nettype wire

// File: verif/acr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module acr_host_model (
  // clock
  input  wire logic ref_clk,
  // requests from the bench
  input  wire logic startReq,
  input  wire logic early,
  // device side
  input  wire logic busy,
  output logic      convert_start_n
);
  int sinceStart = 1000;

  always @(posedge ref_clk)
    sinceStart <= convert_start_n ? sinceStart + 1 : 0;

  // early requests skip the spacing rules, to provoke a refusal
  initial
  begin
    convert_start_n = 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (startReq)
      begin
        if (!early)
        begin
          while (busy || sinceStart < 84)
            @(posedge ref_clk);
          repeat (15) @(posedge ref_clk);
        end
        // bench requests follow closely, never 1 ms apart
        convert_start_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        convert_start_n <= 1'b1;
      end
    end
  end
endmodule : acr_host_model

`default_nettype wire

// File: verif/adc_conversion_readout_timing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_readout_timing_tb_top;
  typedef struct packed {
    acr_pkg::acr_speed_t speed;
    acr_pkg::acr_read_t  rmode;
    logic [1:0]          div;
    logic                csN;
    logic [17:0]         data;
    logic [17:0]         ser;
    logic [4:0]          nBits;
    logic [9:0]          maxBusy;
  } acr_row_t;

  logic                ref_clk = 1'b0;
  logic                reset_n;
  logic                startReq;
  logic                early;
  logic                adcReset;
  logic                chipSelect_n;
  acr_pkg::acr_speed_t speedMode;
  acr_pkg::acr_read_t  readMode;
  logic [1:0]          serial_clock_divider;
  logic [17:0]         coreResult;
  logic                convert_start_n;
  logic                sampleHold;
  logic                busy;
  logic [17:0]         parallelData;
  acr_pkg::acr_pin_t   frameMarker;
  acr_pkg::acr_pin_t   serialClock;
  acr_pkg::acr_pin_t   serial_data_out;
  logic [17:0]         capWord = 18'h00000;
  int                  bitCnt = 0;
  int                  shCount = 0;
  logic                prevSclk = 1'b0;
  logic                slaveSck = 1'b0;
  logic                chainIn = 1'b0;
  logic [19:0]         slaveWord = 20'h00000;
  int                  failures = 0;
  int                  n_compared = 0;
  int                  n;

  acr_row_t rows [0:8] = '{
    '{acr_pkg::SPD_NORMAL, acr_pkg::RD_PARALLEL, 2'b00, 1'b1,
      18'h2A5C3, 18'h00000, 5'h00, 10'h041},
    '{acr_pkg::SPD_FAST, acr_pkg::RD_PARALLEL, 2'b00, 1'b1,
      18'h15A3C, 18'h00000, 5'h00, 10'h030},
    '{acr_pkg::SPD_WIDE_FAST, acr_pkg::RD_PARALLEL, 2'b00, 1'b1,
      18'h3FFFF, 18'h00000, 5'h00, 10'h030},
    '{acr_pkg::SPD_FAST, acr_pkg::RD_MASTER_AFTER, 2'b00, 1'b0,
      18'h20001, 18'h20001, 5'h12, 10'h04E},
    '{acr_pkg::SPD_NORMAL, acr_pkg::RD_MASTER_AFTER, 2'b01, 1'b0,
      18'h12345, 18'h12345, 5'h12, 10'h06C},
    '{acr_pkg::SPD_FAST, acr_pkg::RD_MASTER_AFTER, 2'b10, 1'b0,
      18'h0F0F0, 18'h0F0F0, 5'h12, 10'h0A8},
    '{acr_pkg::SPD_WIDE_FAST, acr_pkg::RD_MASTER_AFTER, 2'b11, 1'b0,
      18'h3C3A5, 18'h3C3A5, 5'h12, 10'h11D},
    '{acr_pkg::SPD_FAST, acr_pkg::RD_MASTER_DURING, 2'b00, 1'b0,
      18'h0AAAA, 18'h3C3A5, 5'h12, 10'h030},
    '{acr_pkg::SPD_FAST, acr_pkg::RD_MASTER_AFTER, 2'b11, 1'b1,
      18'h05555, 18'h00000, 5'h00, 10'h11D}
  };

  always #4 ref_clk = ~ref_clk;

  acr_host_model host_u (
    .ref_clk(ref_clk), .startReq(startReq), .early(early),
    .busy(busy), .convert_start_n(convert_start_n)
  );

  acr_conv_ctrl dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .convert_start_n(convert_start_n), .adcReset(adcReset),
    .chipSelect_n(chipSelect_n), .slaveSerialClock(slaveSck),
    .serial_data_chain_in(chainIn), .speedMode(speedMode),
    .readMode(readMode), .serial_clock_divider(serial_clock_divider),
    .coreResult(coreResult), .sampleHold(sampleHold), .busy(busy),
    .parallelData(parallelData), .frameMarker(frameMarker),
    .serialClock(serialClock), .serial_data_out(serial_data_out)
  );

  // host samples serial data on the rising clock edge
  always @(posedge ref_clk)
  begin
    if (serialClock.oe && serialClock.value && !prevSclk)
    begin
      capWord <= {capWord[16:0], serial_data_out.value};
      bitCnt  <= bitCnt + 1;
    end
    prevSclk <= serialClock.value;
    if (sampleHold)
      shCount <= shCount + 1;
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // sampled on the falling edge, where registered outputs have settled
  task automatic wait_busy(input logic lvl, output int cnt);
    cnt = 0;
    while (busy !== lvl && cnt < 400)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt == 400)
      failures++;
  endtask : wait_busy

  task automatic request();
    @(posedge ref_clk);
    startReq <= 1'b1;
    @(posedge ref_clk);
    startReq <= 1'b0;
  endtask : request

  task automatic run_row(input acr_row_t r);
    int b0;
    @(posedge ref_clk);
    speedMode            <= r.speed;
    readMode             <= r.rmode;
    serial_clock_divider <= r.div;
    chipSelect_n         <= r.csN;
    coreResult           <= r.data;
    early                <= 1'b0;
    repeat (8) @(posedge ref_clk);
    b0 = bitCnt;
    request();
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    check({17'h00000, n <= r.maxBusy}, 18'h00001);
    repeat (2) @(negedge ref_clk);
    check(parallelData, r.data);
    check(18'(bitCnt - b0), 18'(r.nBits));
    if (r.nBits != 5'h00)
      check(capWord, r.ser);
  endtask : run_row

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    stop_test();
  end

  initial
  begin
    int sh0;
    reset_n              = 1'b0;
    startReq             = 1'b0;
    early                = 1'b0;
    adcReset             = 1'b0;
    chipSelect_n         = 1'b1;
    speedMode            = acr_pkg::SPD_NORMAL;
    readMode             = acr_pkg::RD_PARALLEL;
    serial_clock_divider = 2'b00;
    coreResult           = 18'h00000;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 9; i++)
      run_row(rows[i]);
    // slave readout: host clocks the word out, chain bits follow it
    @(posedge ref_clk);
    readMode     <= acr_pkg::RD_SLAVE;
    chipSelect_n <= 1'b0;
    chainIn      <= 1'b1;
    coreResult   <= 18'h2D1E7;
    request();
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    // edges spaced well beyond the pin synchroniser latency
    for (int i = 0; i < 20; i++)
    begin
      repeat (8) @(posedge ref_clk);
      slaveWord <= {slaveWord[18:0], serial_data_out.value};
      slaveSck  <= 1'b1;
      repeat (8) @(posedge ref_clk);
      slaveSck  <= 1'b0;
    end
    check(slaveWord[19:2], 18'h2D1E7);
    check(18'(slaveWord[1:0]), 18'h00003);
    // converter reset: busy held, an early convert is refused
    @(posedge ref_clk);
    readMode <= acr_pkg::RD_PARALLEL;
    adcReset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    adcReset <= 1'b0;
    wait_busy(1'b1, n);
    check({17'h00000, n <= 10}, 18'h00001);
    sh0 = shCount;
    early <= 1'b1;
    request();
    wait_busy(1'b0, n);
    check({17'h00000, n >= 70}, 18'h00001);
    check(18'(shCount - sh0), 18'h00000);
    // reset in mid-conversion drops busy and the marker and clock enables
    early <= 1'b0;
    request();
    wait_busy(1'b1, n);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(negedge ref_clk);
    check({busy, frameMarker.oe, serialClock.oe}, 18'h00000);
    // two edges low, so no stale edge is sampled at release
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    run_row(rows[1]);
    stop_test();
  end
endmodule : adc_conversion_readout_timing_tb_top

`default_nettype wire
